// ---- hdl/fdc_cmd_dev.sv ----
`timescale 1ns/1ns
`default_nettype none
module fdc_cmd_dev (
    input  wire logic       clk_i,
    input  wire logic       sys_rst_i,
    fdc_host_if.device      bus,
    output logic            retain_o,
    output logic            queue_off_o,
    output logic            implied_seek_o,
    output logic            poll_off_o,
    output logic [3:0]      queue_threshold_o,
    output logic [7:0]      precomp_start_track_o,
    output logic            write_queue_off_o,
    output logic            write_via_queue_o,
    output logic            read_queue_off_o,
    output logic            burst_off_o,
    output logic [31:0]     mode_o,
    output logic            xfer_start_o,
    output logic [7:0]      xfer_opcode_o,
    output logic [55:0]     xfer_params_o,
    output logic [7:0]      last_sector_number_o
);

    typedef enum logic [1:0] {ST_CMD, ST_PARAM, ST_RESULT} phase_e;

    phase_e                  phase_r;
    fdc_cmd_pkg::cmd_kind_e  kind_r;
    logic [3:0]              cnt_r;
    logic [7:0]              result_r;
    logic                    lock_pend_r;
    logic                    lock_val_r;
    logic                    retain_r;
    logic [7:0]              cfg_r;
    logic [7:0]              precomp_start_track_r;
    logic [7:0]              mode_r [0:3];
    logic [7:0]              xfer_r [0:fdc_cmd_pkg::XFER_KEPT-1];
    logic [7:0]              xfer_op_r;
    logic                    start_r;

    function automatic logic is_xfer(input logic [7:0] op);
        unique case (op[4:0])
            5'h05, 5'h06, 5'h09, 5'h0c, 5'h11, 5'h16, 5'h19, 5'h1d: is_xfer = 1'b1;
            default: is_xfer = 1'b0;
        endcase
    endfunction

    wire       cmd_wr    = bus.wr_stb && (phase_r == ST_CMD);
    wire       param_wr  = bus.wr_stb && (phase_r == ST_PARAM);
    wire       res_rd    = bus.rd_stb && (phase_r == ST_RESULT);
    wire [7:0] op        = bus.wr_data;
    wire       op_cfg    = (op == fdc_cmd_pkg::OP_CONFIGURE);
    wire       op_mode   = (op == fdc_cmd_pkg::OP_MODE);
    wire       op_xfer   = is_xfer(op);
    wire       op_lock   = (op[6:0] == fdc_cmd_pkg::LOCK_PATTERN);
    wire       op_legal  = op_cfg || op_mode || op_xfer || op_lock;
    wire [3:0] cnt_last  = (kind_r == fdc_cmd_pkg::K_CONFIG) ? fdc_cmd_pkg::CONFIG_PARAMS - 4'h1 :
                           (kind_r == fdc_cmd_pkg::K_MODE)   ? fdc_cmd_pkg::MODE_PARAMS - 4'h1 :
                                                               fdc_cmd_pkg::XFER_PARAMS - 4'h1;
    wire       param_end = param_wr && (cnt_r == cnt_last);
    wire       lock_take = res_rd && lock_pend_r && !bus.soft_rst;

    wire [7:0] lock_result = {3'h0, op[fdc_cmd_pkg::LOCK_REQ_BIT], 4'h0};

    // Phase sequencing
    always_ff @(posedge clk_i) begin
        if (sys_rst_i || bus.soft_rst) begin
            phase_r     <= ST_CMD;
            kind_r      <= fdc_cmd_pkg::K_CONFIG;
            cnt_r       <= 4'h0;
            result_r    <= 8'h00;
            lock_pend_r <= 1'b0;
            lock_val_r  <= 1'b0;
        end else if (cmd_wr) begin
            cnt_r <= 4'h0;
            if (op_cfg) begin
                kind_r  <= fdc_cmd_pkg::K_CONFIG;
                phase_r <= ST_PARAM;
            end else if (op_mode) begin
                kind_r  <= fdc_cmd_pkg::K_MODE;
                phase_r <= ST_PARAM;
            end else if (op_xfer) begin
                kind_r  <= fdc_cmd_pkg::K_XFER;
                phase_r <= ST_PARAM;
            end else if (op_lock) begin
                result_r    <= lock_result;
                lock_pend_r <= 1'b1;
                lock_val_r  <= op[fdc_cmd_pkg::LOCK_REQ_BIT];
                phase_r     <= ST_RESULT;
            end else begin
                result_r <= fdc_cmd_pkg::INVALID_STATUS;
                phase_r  <= ST_RESULT;
            end
        end else if (param_wr) begin
            cnt_r <= cnt_r + 4'h1;
            if (param_end) begin
                phase_r <= ST_CMD;
            end
        end else if (res_rd) begin
            lock_pend_r <= 1'b0;
            phase_r     <= ST_CMD;
        end
    end

    // Retain flag, cleared by system reset, otherwise only moved by a completed lock
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            retain_r <= 1'b0;
        end else if (lock_take) begin
            retain_r <= lock_val_r;
        end
    end

    wire       cfg_byte   = param_wr && (kind_r == fdc_cmd_pkg::K_CONFIG);
    wire       mode_byte  = param_wr && (kind_r == fdc_cmd_pkg::K_MODE);
    wire [7:0] cfg_soft   = retain_r ?
        {1'b0, fdc_cmd_pkg::CFG_DEFAULT[fdc_cmd_pkg::CFG_EIS], cfg_r[fdc_cmd_pkg::CFG_QUEUE],
         fdc_cmd_pkg::CFG_DEFAULT[fdc_cmd_pkg::CFG_POLL], cfg_r[3:0]} :
        fdc_cmd_pkg::CFG_DEFAULT;
    wire [7:0] precomp_start_track_soft = retain_r ? precomp_start_track_r : fdc_cmd_pkg::PRECOMP_START_TRACK_DEFAULT;
    wire [7:0] mode1_soft  = retain_r ?
        {mode_r[1][7:5], fdc_cmd_pkg::MODE1_DEFAULT[4:0]} :
        fdc_cmd_pkg::MODE1_DEFAULT;

    // Configure settings
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            cfg_r    <= fdc_cmd_pkg::CFG_DEFAULT;
            precomp_start_track_r <= fdc_cmd_pkg::PRECOMP_START_TRACK_DEFAULT;
        end else if (bus.soft_rst) begin
            cfg_r    <= cfg_soft;
            precomp_start_track_r <= precomp_start_track_soft;
        end else if (cfg_byte && cnt_r == 4'h1) begin
            cfg_r    <= {1'b0, bus.wr_data[6:0]};
        end else if (cfg_byte && cnt_r == 4'h2) begin
            precomp_start_track_r <= bus.wr_data;
        end
    end

    // Mode settings
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            mode_r[0] <= fdc_cmd_pkg::MODE0_DEFAULT;
            mode_r[1] <= fdc_cmd_pkg::MODE1_DEFAULT;
            mode_r[2] <= fdc_cmd_pkg::MODE2_DEFAULT;
            mode_r[3] <= fdc_cmd_pkg::MODE3_DEFAULT;
        end else if (bus.soft_rst) begin
            mode_r[0] <= fdc_cmd_pkg::MODE0_DEFAULT;
            mode_r[1] <= mode1_soft;
            mode_r[2] <= fdc_cmd_pkg::MODE2_DEFAULT;
            mode_r[3] <= fdc_cmd_pkg::MODE3_DEFAULT;
        end else if (mode_byte) begin
            mode_r[cnt_r[1:0]] <= bus.wr_data;
        end
    end

    // Transfer command capture, gap slot dropped
    wire       xfer_byte = param_wr && (kind_r == fdc_cmd_pkg::K_XFER);
    wire       xfer_keep = xfer_byte && (cnt_r != fdc_cmd_pkg::XFER_GAP_IDX);
    wire [2:0] xfer_idx  = (cnt_r > fdc_cmd_pkg::XFER_GAP_IDX) ? cnt_r[2:0] - 3'h1 : cnt_r[2:0];

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            xfer_op_r <= 8'h00;
            start_r   <= 1'b0;
            for (int i = 0; i < fdc_cmd_pkg::XFER_KEPT; i++) begin
                xfer_r[i] <= 8'h00;
            end
        end else begin
            start_r <= param_end && (kind_r == fdc_cmd_pkg::K_XFER) && !bus.soft_rst;
            if (cmd_wr && op_xfer) begin
                xfer_op_r <= op;
            end
            if (xfer_keep) begin
                xfer_r[xfer_idx] <= bus.wr_data;
            end
        end
    end

    genvar g;
    generate
        for (g = 0; g < fdc_cmd_pkg::XFER_KEPT; g++) begin : g_xfer
            assign xfer_params_o[8*g +: 8] = xfer_r[g];
        end
        for (g = 0; g < 4; g++) begin : g_mode
            assign mode_o[8*g +: 8] = mode_r[g];
        end
    endgenerate

    // Host-visible status and data
    assign bus.main_status_reg = {1'b1, (phase_r == ST_RESULT), 1'b0,
                                  (phase_r != ST_CMD), 4'h0};
    assign bus.rd_data = result_r;
    assign bus.irq     = 1'b0;

    assign retain_o              = retain_r;
    assign queue_off_o           = cfg_r[fdc_cmd_pkg::CFG_QUEUE];
    assign implied_seek_o        = cfg_r[fdc_cmd_pkg::CFG_EIS];
    assign poll_off_o            = cfg_r[fdc_cmd_pkg::CFG_POLL];
    assign queue_threshold_o     = cfg_r[fdc_cmd_pkg::CFG_THR_MSB:0];
    assign precomp_start_track_o = precomp_start_track_r;
    assign write_queue_off_o     = mode_r[1][fdc_cmd_pkg::MODE_WQ_OFF];
    assign write_via_queue_o     = !cfg_r[fdc_cmd_pkg::CFG_QUEUE] &&
                                   !mode_r[1][fdc_cmd_pkg::MODE_WQ_OFF];
    assign read_queue_off_o      = mode_r[1][fdc_cmd_pkg::MODE_RQ_OFF];
    assign burst_off_o           = mode_r[1][fdc_cmd_pkg::MODE_BST_OFF];
    assign xfer_start_o          = start_r;
    assign xfer_opcode_o         = xfer_op_r;
    assign last_sector_number_o  = xfer_r[5];

endmodule
`default_nettype wire

// ---- hdl/fdc_cmd_pkg.sv ----
package fdc_cmd_pkg;

    // Command opcodes and lock pattern
    localparam logic [7:0] OP_CONFIGURE  = 8'h13;
    localparam logic [7:0] OP_MODE       = 8'h01;
    localparam logic [6:0] LOCK_PATTERN  = 7'h14;
    localparam int         LOCK_REQ_BIT  = 7;

    // Result bytes
    localparam logic [7:0] INVALID_STATUS = 8'h80;
    localparam int         LOCK_RES_BIT   = 4;

    // Main status register bit positions
    localparam int MSR_RQM  = 7;
    localparam int MSR_DIO  = 6;
    localparam int MSR_BUSY = 4;

    // Parameter byte counts after the opcode
    localparam logic [3:0] CONFIG_PARAMS = 4'h3;
    localparam logic [3:0] MODE_PARAMS   = 4'h4;
    localparam logic [3:0] XFER_PARAMS   = 4'h8;
    localparam logic [3:0] XFER_GAP_IDX  = 4'h6;
    localparam int         XFER_KEPT     = 7;

    // Configure byte layout: 0 EIS FIFO POLL QUEUE_THRESHOLD[3:0]
    localparam int CFG_EIS      = 6;
    localparam int CFG_QUEUE    = 5;
    localparam int CFG_POLL     = 4;
    localparam int CFG_THR_MSB  = 3;

    // Mode second byte layout: WRITE_QUEUE_OFF READ_QUEUE_OFF BURST_OFF R255 0000
    localparam int MODE_WQ_OFF  = 7;
    localparam int MODE_RQ_OFF  = 6;
    localparam int MODE_BST_OFF = 5;

    // Values after reset
    localparam logic [7:0] CFG_DEFAULT    = 8'h20;
    localparam logic [7:0] PRECOMP_START_TRACK_DEFAULT = 8'h00;
    localparam logic [7:0] MODE0_DEFAULT  = 8'h02;
    localparam logic [7:0] MODE1_DEFAULT  = 8'h00;
    localparam logic [7:0] MODE2_DEFAULT  = 8'hc8;
    localparam logic [7:0] MODE3_DEFAULT  = 8'h00;

    // Recommended format gap for common media
    localparam logic [7:0] SIZE_512       = 8'h02;
    localparam logic [7:0] EOT_360K_720K  = 8'h09;
    localparam logic [7:0] EOT_1M2        = 8'h0f;
    localparam logic [7:0] EOT_1M44       = 8'h12;
    localparam logic [7:0] EOT_2M88       = 8'h24;
    localparam logic [7:0] GAP_360K_720K  = 8'h50;
    localparam logic [7:0] GAP_1M2        = 8'h54;
    localparam logic [7:0] GAP_1M44       = 8'h6c;
    localparam logic [7:0] GAP_2M88       = 8'h53;
    localparam logic [7:0] GAP_FALLBACK   = 8'hff;

    typedef enum logic [1:0] {K_CONFIG, K_MODE, K_XFER} cmd_kind_e;

endpackage

// ---- hdl/fdc_host_if.sv ----
`timescale 1ns/1ns
`default_nettype none
interface fdc_host_if;
    logic       wr_stb;
    logic [7:0] wr_data;
    logic       rd_stb;
    logic [7:0] rd_data;
    logic [7:0] main_status_reg;
    logic       irq;
    logic       soft_rst;

    modport device (
        input  wr_stb,
        input  wr_data,
        input  rd_stb,
        input  soft_rst,
        output rd_data,
        output main_status_reg,
        output irq
    );

    modport host (
        output wr_stb,
        output wr_data,
        output rd_stb,
        output soft_rst,
        input  rd_data,
        input  main_status_reg,
        input  irq
    );
endinterface
`default_nettype wire

// ---- hdl/fdc_cmd_host.sv ----
`timescale 1ns/1ns
`default_nettype none
module fdc_cmd_host (
    input  wire logic       clk_i,
    input  wire logic       sys_rst_i,
    fdc_host_if.host        bus,
    input  wire logic       usr_wr_i,
    input  wire logic [7:0] usr_byte_i,
    output logic            usr_wr_ready_o,
    input  wire logic       usr_rd_i,
    output logic            usr_rd_ready_o,
    output logic            usr_rd_valid_o,
    output logic [7:0]      usr_rd_byte_o,
    input  wire logic       usr_soft_rst_i,
    output logic            lock_wait_o,
    input  wire logic [7:0] media_size_code_i,
    input  wire logic [7:0] media_last_sector_i,
    output logic [7:0]      format_gap_o
);

    logic       wr_r;
    logic [7:0] wdata_r;
    logic       rd_r;
    logic       rd_seen_r;
    logic       rvalid_r;
    logic [7:0] rbyte_r;
    logic       lock_wait_r;
    logic       srst_r;
    logic [7:0] gap_r;

    function automatic logic [7:0] gap_for(input logic [7:0] size, input logic [7:0] last_sector_number);
        gap_for = fdc_cmd_pkg::GAP_FALLBACK;
        if (size == fdc_cmd_pkg::SIZE_512) begin
            unique case (last_sector_number)
                fdc_cmd_pkg::EOT_360K_720K: gap_for = fdc_cmd_pkg::GAP_360K_720K;
                fdc_cmd_pkg::EOT_1M2:       gap_for = fdc_cmd_pkg::GAP_1M2;
                fdc_cmd_pkg::EOT_1M44:      gap_for = fdc_cmd_pkg::GAP_1M44;
                fdc_cmd_pkg::EOT_2M88:      gap_for = fdc_cmd_pkg::GAP_2M88;
                default:                    gap_for = fdc_cmd_pkg::GAP_FALLBACK;
            endcase
        end
    endfunction

    wire msr_rqm  = bus.main_status_reg[fdc_cmd_pkg::MSR_RQM];
    wire msr_dio  = bus.main_status_reg[fdc_cmd_pkg::MSR_DIO];
    wire busy     = wr_r || rd_r || rd_seen_r || srst_r;
    wire wr_ok    = msr_rqm && !msr_dio && !lock_wait_r && !busy;
    wire rd_ok    = msr_rqm && msr_dio && !busy;
    wire wr_go    = usr_wr_i && wr_ok;
    wire rd_go    = usr_rd_i && rd_ok;
    wire is_lock  = (usr_byte_i[6:0] == fdc_cmd_pkg::LOCK_PATTERN);
    // Only an opcode byte opens a lock wait; parameter bytes may share the pattern
    wire msr_idle = !bus.main_status_reg[fdc_cmd_pkg::MSR_BUSY];

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            wr_r        <= 1'b0;
            wdata_r     <= 8'h00;
            rd_r        <= 1'b0;
            rd_seen_r   <= 1'b0;
            rvalid_r    <= 1'b0;
            rbyte_r     <= 8'h00;
            lock_wait_r <= 1'b0;
            srst_r      <= 1'b0;
        end else begin
            srst_r    <= usr_soft_rst_i;
            wr_r      <= wr_go && !usr_soft_rst_i;
            rd_r      <= rd_go && !usr_soft_rst_i;
            rd_seen_r <= rd_r;
            rvalid_r  <= rd_r;
            if (wr_go) begin
                wdata_r <= usr_byte_i;
            end
            if (rd_r) begin
                rbyte_r <= bus.rd_data;
            end
            if (usr_soft_rst_i) begin
                lock_wait_r <= 1'b0;
            end else if (wr_go && is_lock && msr_idle) begin
                lock_wait_r <= 1'b1;
            end else if (rd_r) begin
                lock_wait_r <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            gap_r <= fdc_cmd_pkg::GAP_FALLBACK;
        end else begin
            gap_r <= gap_for(media_size_code_i, media_last_sector_i);
        end
    end

    assign bus.wr_stb   = wr_r;
    assign bus.wr_data  = wdata_r;
    assign bus.rd_stb   = rd_r;
    assign bus.soft_rst = srst_r;

    assign usr_wr_ready_o = wr_ok;
    assign usr_rd_ready_o = rd_ok;
    assign usr_rd_valid_o = rvalid_r;
    assign usr_rd_byte_o  = rbyte_r;
    assign lock_wait_o    = lock_wait_r;
    assign format_gap_o   = gap_r;

endmodule
`default_nettype wire

// ---- bench/fdc_cmd_checker.sv ----
`timescale 1ns/1ns
`default_nettype none
module fdc_cmd_checker (
    input wire logic       clk_i,
    input wire logic       sys_rst_i,
    input wire logic       wr_stb,
    input wire logic [7:0] wr_data,
    input wire logic       rd_stb,
    input wire logic [7:0] rd_data,
    input wire logic [7:0] main_status_reg,
    input wire logic       irq,
    input wire logic       soft_rst
);
    wire idle_w = (main_status_reg == 8'h80) && !soft_rst;
    wire lock_w = (wr_data[6:0] == 7'h14);
    wire xfer_w = wr_data[4:0] inside {5'h05, 5'h06, 5'h09, 5'h0c, 5'h11, 5'h16, 5'h19, 5'h1d};
    wire bad_w  = !lock_w && !xfer_w && (wr_data != 8'h13) && (wr_data != 8'h01);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);
    a_no_irq: assert property (irq == 1'b0)
        else $error("interrupt raised");
    a_invalid_answer: assert property (wr_stb && idle_w && bad_w |=>
        main_status_reg == 8'hd0 && rd_data == 8'h80) else $error("bad invalid answer");
    a_lock_answer: assert property (wr_stb && idle_w && lock_w |=>
        main_status_reg == 8'hd0 && rd_data == (($past(wr_data) >> 3) & 8'h10))
        else $error("bad lock answer");
    a_result_stands: assert property (main_status_reg[6] && !rd_stb && !soft_rst |=>
        main_status_reg[6] && $stable(rd_data)) else $error("result dropped unread");
    a_read_to_idle: assert property (main_status_reg[6] && rd_stb |=>
        main_status_reg == 8'h80) else $error("no return to command phase");
    a_soft_abort: assert property (soft_rst |=> main_status_reg == 8'h80)
        else $error("soft reset did not abort");
    a_spare_zero: assert property ((main_status_reg & 8'h2f) == 8'h00 && main_status_reg[7])
        else $error("status spare bits set");
    a_result_entry: assert property ($rose(main_status_reg[6]) |->
        $past(wr_stb) && $past(main_status_reg) == 8'h80) else $error("result from nowhere");
    c_invalid: cover property (wr_stb && idle_w && bad_w);
    c_lock_set: cover property (wr_stb && idle_w && lock_w && wr_data[7]);
    c_result_read: cover property (main_status_reg[6] && rd_stb);
endmodule
`default_nettype wire

// ---- bench/floppy_cmd_lock_and_invalid_tb_top.sv ----
`timescale 1ns/1ns
`default_nettype none
module floppy_cmd_lock_and_invalid_tb_top;
    logic        clk_i, sys_rst_i, usr_wr_i, usr_rd_i, usr_soft_rst_i;
    logic [7:0]  usr_byte_i, media_size_code_i, media_last_sector_i, rb;
    logic        usr_wr_ready_o, usr_rd_ready_o, usr_rd_valid_o, lock_wait_o, retain_o;
    logic [7:0]  usr_rd_byte_o, format_gap_o, precomp_start_track_o, xfer_opcode_o;
    logic [7:0]  last_sector_number_o;
    logic        queue_off_o, implied_seek_o, poll_off_o, write_queue_off_o, write_via_queue_o;
    logic        read_queue_off_o, burst_off_o, xfer_start_o, fault_retain;
    logic [3:0]  queue_threshold_o;
    logic [31:0] mode_o;
    logic [55:0] xfer_params_o;
    int          failures = 0;
    int          samples_checked = 0;
    int          xfer_starts = 0;
    fdc_host_if  bus_if ();
    fdc_host_if  fault_if ();
    wire [12:0]  cfg_view = {queue_off_o, queue_threshold_o, precomp_start_track_o};
    wire [16:0]  fault_view = {fault_retain, fault_if.main_status_reg, fault_if.rd_data};

    fdc_cmd_dev fdc_cmd_dev_i (.clk_i, .sys_rst_i, .bus(bus_if.device), .retain_o,
        .queue_off_o, .implied_seek_o, .poll_off_o, .queue_threshold_o, .precomp_start_track_o,
        .write_queue_off_o, .write_via_queue_o, .read_queue_off_o, .burst_off_o, .mode_o,
        .xfer_start_o, .xfer_opcode_o, .xfer_params_o, .last_sector_number_o);
    fdc_cmd_dev fdc_cmd_dev_i2 (.clk_i, .sys_rst_i, .bus(fault_if.device), .retain_o(fault_retain),
        .queue_off_o(), .implied_seek_o(), .poll_off_o(), .queue_threshold_o(),
        .precomp_start_track_o(), .write_queue_off_o(), .write_via_queue_o(),
        .read_queue_off_o(), .burst_off_o(), .mode_o(), .xfer_start_o(), .xfer_opcode_o(),
        .xfer_params_o(), .last_sector_number_o());
    fdc_cmd_host fdc_cmd_host_i (.clk_i, .sys_rst_i, .bus(bus_if.host), .usr_wr_i, .usr_byte_i,
        .usr_wr_ready_o, .usr_rd_i, .usr_rd_ready_o, .usr_rd_valid_o, .usr_rd_byte_o,
        .usr_soft_rst_i, .lock_wait_o, .media_size_code_i, .media_last_sector_i, .format_gap_o);
    fdc_cmd_checker fdc_cmd_checker_i (.clk_i, .sys_rst_i, .wr_stb(bus_if.wr_stb),
        .wr_data(bus_if.wr_data), .rd_stb(bus_if.rd_stb), .rd_data(bus_if.rd_data),
        .main_status_reg(bus_if.main_status_reg), .irq(bus_if.irq), .soft_rst(bus_if.soft_rst));

    // Counts transfer start pulses, sampled where they are settled
    always @(negedge clk_i) begin
        if (xfer_start_o === 1'b1) begin
            xfer_starts++;
        end
    end

    task automatic stop_test();
        $display("checks %0d mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic chk(input string name, input logic [63:0] exp, input logic [63:0] got);
        samples_checked++;
        if (got !== exp) begin
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
            failures++;
        end
    endtask

    task automatic give_up(input string name);
        $display("[FAIL] %s expected done seen timeout", name);
        failures++;
        stop_test();
    endtask

    task automatic send(input logic [7:0] b);
        int n = 0;
        @(posedge clk_i);
        usr_wr_i <= 1'b1;
        usr_byte_i <= b;
        do begin @(negedge clk_i); n++; end while (usr_wr_ready_o !== 1'b1 && n < 50);
        if (usr_wr_ready_o !== 1'b1) give_up("write ready");
        @(posedge clk_i);
        usr_wr_i <= 1'b0;
    endtask

    task automatic send_seq(input logic [7:0] q[$]);
        foreach (q[i]) send(q[i]);
    endtask

    task automatic recv(output logic [7:0] b);
        int n = 0;
        @(posedge clk_i);
        usr_rd_i <= 1'b1;
        do begin @(negedge clk_i); n++; end while (usr_rd_ready_o !== 1'b1 && n < 50);
        if (usr_rd_ready_o !== 1'b1) give_up("read ready");
        @(posedge clk_i);
        usr_rd_i <= 1'b0;
        n = 0;
        do begin @(negedge clk_i); n++; end while (usr_rd_valid_o !== 1'b1 && n < 10);
        if (usr_rd_valid_o !== 1'b1) give_up("read valid");
        b = usr_rd_byte_o;
    endtask

    task automatic soft_reset();
        @(posedge clk_i);
        usr_soft_rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        usr_soft_rst_i <= 1'b0;
        repeat (4) @(negedge clk_i);
    endtask

    // Drives the second device directly, free to break the host's ordering
    task automatic poke(input logic w, input logic r, input logic s, input logic [7:0] d);
        @(posedge clk_i);
        fault_if.wr_stb <= w;
        fault_if.rd_stb <= r;
        fault_if.soft_rst <= s;
        fault_if.wr_data <= d;
        @(posedge clk_i);
        fault_if.wr_stb <= 1'b0;
        fault_if.rd_stb <= 1'b0;
        fault_if.soft_rst <= 1'b0;
        fault_if.wr_data <= ~d;
        @(negedge clk_i);
    endtask

    task automatic lock(input logic v);
        send({v, 7'h14});
        repeat (3) @(negedge clk_i);
        chk("lock pending", 1'b1, lock_wait_o);
        chk("retain before read", !v, retain_o);
        recv(rb);
        chk("lock result", {3'b000, v, 4'h0}, rb);
        chk("retain after read", v, retain_o);
    endtask

    task automatic t_fault();
        poke(1'b1, 1'b0, 1'b0, 8'h94);
        poke(1'b0, 1'b0, 1'b1, 8'h00);
        chk("abandoned lock", {1'b0, 8'h80}, {fault_retain, fault_if.main_status_reg});
        poke(1'b1, 1'b0, 1'b0, 8'h94);
        poke(1'b1, 1'b0, 1'b0, 8'hff);
        chk("early command", 17'h0d010, fault_view);
        poke(1'b0, 1'b1, 1'b0, 8'h00);
        chk("late read", {1'b1, 8'h80}, {fault_retain, fault_if.main_status_reg});
    endtask

    task automatic t_invalid();
        logic [7:0] ops[3] = '{8'hff, 8'h18, 8'h02};
        foreach (ops[i]) begin
            send(ops[i]);
            repeat (3) @(negedge clk_i);
            chk("status in result", 8'hd0, bus_if.main_status_reg);
            recv(rb);
            chk("invalid status", 8'h80, rb);
            chk("interrupt", 1'b0, bus_if.irq);
            chk("status after read", 8'h80, bus_if.main_status_reg);
        end
    endtask

    task automatic t_retain();
        send_seq('{8'h13, 8'h00, 8'h5b, 8'h37});
        repeat (4) @(negedge clk_i);
        chk("write via queue", 1'b1, write_via_queue_o);
        chk("config flags", 2'b11, {implied_seek_o, poll_off_o});
        send_seq('{8'h01, 8'h00, 8'he0, 8'h00, 8'h00});
        repeat (4) @(negedge clk_i);
        chk("write bypass", 1'b0, write_via_queue_o);
        lock(1'b1);
        soft_reset();
        chk("kept config", 13'h0b37, cfg_view);
        chk("unkept flags", 2'b00, {implied_seek_o, poll_off_o});
        chk("kept mode", 3'b111, {write_queue_off_o, read_queue_off_o, burst_off_o});
        lock(1'b0);
        soft_reset();
        chk("reset config", 13'h1000, cfg_view);
        chk("reset mode", 3'b000, {write_queue_off_o, read_queue_off_o, burst_off_o});
    endtask

    task automatic t_xfer();
        logic [7:0] gaps[2] = '{8'h1b, 8'hff};
        foreach (gaps[i]) begin
            send_seq('{8'h46, 8'h00, 8'h01, 8'h02, 8'h03, 8'h02, 8'h12, gaps[i], 8'hff});
            repeat (4) @(negedge clk_i);
            chk("kept parameters", 56'hff_12_02_03_02_01_00, xfer_params_o);
            chk("last sector", 8'h12, last_sector_number_o);
            chk("transfer opcode", 8'h46, xfer_opcode_o);
        end
        chk("transfer starts", 2, xfer_starts);
    endtask

    task automatic t_gap();
        logic [23:0] tab[5] = '{24'h02_09_50, 24'h02_0f_54, 24'h02_12_6c,
                                24'h02_24_53, 24'h03_09_ff};
        foreach (tab[i]) begin
            @(posedge clk_i);
            media_size_code_i <= tab[i][23:16];
            media_last_sector_i <= tab[i][15:8];
            repeat (3) @(negedge clk_i);
            chk("format gap", tab[i][7:0], format_gap_o);
        end
    endtask

    task automatic t_hw_reset();
        lock(1'b1);
        send_seq('{8'h01, 8'h11, 8'he0, 8'h22, 8'h33});
        repeat (4) @(negedge clk_i);
        chk("mode written", 32'h3322e011, mode_o);
        @(posedge clk_i);
        sys_rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        @(negedge clk_i);
        chk("retain after reset", 1'b0, retain_o);
        chk("mode defaults", 32'h00c80002, mode_o);
    endtask

    initial begin
        clk_i = 1'b0;
        forever #2 clk_i = ~clk_i;
    end

    initial begin
        sys_rst_i = 1'b1;
        usr_wr_i = 1'b0;
        usr_rd_i = 1'b0;
        usr_soft_rst_i = 1'b0;
        usr_byte_i = 8'h00;
        media_size_code_i = 8'h00;
        media_last_sector_i = 8'h00;
        fault_if.wr_stb = 1'b0;
        fault_if.rd_stb = 1'b0;
        fault_if.soft_rst = 1'b0;
        fault_if.wr_data = 8'h00;
        repeat (5) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        t_fault();
        t_invalid();
        t_retain();
        t_xfer();
        t_gap();
        t_hw_reset();
        stop_test();
    end
endmodule
`default_nettype wire
